// ---- core/dbcsr_regs.v ----
// i2c slave with two output command registers and a read-only health register
//
// Function
// [R1] two independent command registers at 0x02 and 0x03, each steering only its own output.
// [R2] bits 6..4 set the ramp as one 10 mV step per 2^N switching cycles, 000 one, 111 128.
// [R3] each ramp code step doubles the cycles per step, 010 four up to 110 sixty-four.
// [R4] bits 2..1 pick mode: 00 mode pin, 01 fixed frequency, 10 auto skipping, 11 reserved.
// [R5] bit 0 at 0 keeps the output on and at 1 turns it off.
// [R6] the status register at 0x04 is read-only and writes do not change it.
// [R7] status bit 2 shows the over-temperature warning input.
// [R8] status bit 1 shows that output two is in regulation.
// [R9] status bit 0 shows that output one is in regulation.
// [R10] reserved bits read as zero and writes to them are ignored.
// [R11] a write is start, address, register byte and data byte, each acked, applied on the data byte.
// [R12] with both hardware enable pins low serial updates are ignored; software disables do not stop it.
//
// Interface notes
// - scl and sda are sampled on clk_i, so every scl phase must last at least three clocks.
// - the block only ever pulls sda low; sda_o stays low and sda_oe_n_o gates the pull.
// - there is no clock stretching; every answer is ready one clock after an scl edge.
// - only 7-bit addressing at SLAVE_ADDR is answered; other addresses get no ack.
// - the register pointer steps on after every data byte written.
// - a read returns the pointed register and steps on after every host ack.
// - a host nack ends a read; unmapped offsets read as zero.
// - writes to the status register or to unmapped offsets are acked and dropped.
// - both hardware enable pins low hold the serial engine idle and drop any frame.
// - software output disables leave the serial engine fully working.
// - control outputs follow a write two clocks after the data byte completes.
`timescale 1ns/1ps
`include "dbcsr_regs.vh"

module dbcsr_regs #(
    parameter [6:0] SLAVE_ADDR = `DBCSR_SLAVE_ADDR
) (
    input wire clk_i,
    input wire reset_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_n_o,
    input wire output1_hw_enable_pin_i,
    input wire output2_hw_enable_pin_i,
    input wire thermal_warning_i,
    input wire output1_in_regulation_i,
    input wire output2_in_regulation_i,
    input wire pulse_skip_pin_i,
    output reg [7:0] output1_ramp_cycles_o,
    output reg [7:0] output2_ramp_cycles_o,
    output reg output1_fixed_freq_o,
    output reg output2_fixed_freq_o,
    output reg output1_off_o,
    output reg output2_off_o
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_REG = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_READ = 5'h10;

    // ramp code to cycles per 10 mV step
    function [7:0] ramp_cycles;
        input [2:0] code;
        begin
            ramp_cycles = 8'h01 << code;
        end
    endfunction

    // light-load mode resolved against the mode pin; reserved keeps fixed frequency
    function fixed_freq;
        input [1:0] mode;
        input skip_pin;
        begin
            case (mode)
                `DBCSR_MODE_PIN: fixed_freq = ~skip_pin;
                `DBCSR_MODE_FIXED: fixed_freq = 1'b1;
                `DBCSR_MODE_AUTO: fixed_freq = 1'b0;
                default: fixed_freq = 1'b1;
            endcase
        end
    endfunction

    reg scl_q;
    reg sda_q;
    reg [4:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] reg_ptr_q;
    reg [7:0] output1_control_q;
    reg [7:0] output2_control_q;
    reg [7:0] system_health_q;
    reg ack_q;
    reg tx_q;
    reg [7:0] tx_shift_q;

    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_det = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_det = scl_i & scl_q & ~sda_q & sda_i;
    // R12 hardware shutdown
    wire bus_allowed = output1_hw_enable_pin_i | output2_hw_enable_pin_i;

    // pulls low for ack or a zero data bit
    wire pull_low = ack_q | (tx_q & ~tx_shift_q[7]);
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~pull_low;

    function [7:0] read_mux;
        input [7:0] ptr;
        input [7:0] c1;
        input [7:0] c2;
        input [7:0] hl;
        begin
            case (ptr)
                `DBCSR_OUT1_CTRL_OFS: read_mux = c1;
                `DBCSR_OUT2_CTRL_OFS: read_mux = c2;
                `DBCSR_HEALTH_OFS: read_mux = hl;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // read data for the current and the next pointer
    wire [7:0] read_now = read_mux(reg_ptr_q, output1_control_q, output2_control_q,
        system_health_q);
    wire [7:0] read_next = read_mux(reg_ptr_q + 8'h01, output1_control_q,
        output2_control_q, system_health_q);
    reg [7:0] system_health_d;

    // R6 status from inputs only, reserved bits zero
    always @* begin
        system_health_d = 8'h00;
        // R7 thermal warning
        system_health_d[`DBCSR_HOT_BIT] = thermal_warning_i;
        // R8 output two good
        system_health_d[`DBCSR_PG2_BIT] = output2_in_regulation_i;
        // R9 output one good
        system_health_d[`DBCSR_PG1_BIT] = output1_in_regulation_i;
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i)
            system_health_q <= `DBCSR_HEALTH_RST;
        else
            system_health_q <= system_health_d;
    end

    // bit_cnt_q counts scl rises within a byte; 8 marks the last bit
    // and 9 the acknowledge slot of a byte sent to the host
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            reg_ptr_q <= 8'h00;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
            tx_shift_q <= 8'h00;
        end else if (stop_det || !bus_allowed) begin
            state_q <= ST_IDLE;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
        end else if (scl_rise && !ack_q && !tx_q) begin
            shift_q <= {shift_q[6:0], sda_i};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (scl_rise && tx_q) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            // master nack on the ninth bit ends the read
            if (bit_cnt_q == 4'h8 && sda_i) begin
                state_q <= ST_IDLE;
                tx_q <= 1'b0;
            end
        end else if (scl_fall) begin
            if (ack_q) begin
                ack_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                if (state_q == ST_READ) begin
                    tx_q <= 1'b1;
                    tx_shift_q <= read_now;
                end
            end else if (tx_q) begin
                if (bit_cnt_q == 4'h8) begin
                    // let go of sda so the host can ack or nack
                    tx_shift_q <= 8'hff;
                end else if (bit_cnt_q == 4'h9) begin
                    bit_cnt_q <= 4'h0;
                    reg_ptr_q <= reg_ptr_q + 8'h01;
                    tx_shift_q <= read_next;
                    tx_q <= (state_q == ST_READ);
                end else begin
                    tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                end
            end else if (!tx_q && state_q == ST_READ && bit_cnt_q == 4'h0) begin
                tx_q <= 1'b0;
            end else if (bit_cnt_q == 4'h8) begin
                // R11 acknowledge each byte
                case (state_q)
                    ST_ADDR: begin
                        if (shift_q[7:1] == SLAVE_ADDR) begin
                            ack_q <= 1'b1;
                            state_q <= shift_q[0] ? ST_READ : ST_REG;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        ack_q <= 1'b1;
                        reg_ptr_q <= shift_q;
                        state_q <= ST_DATA;
                    end
                    ST_DATA: begin
                        // R11 apply on data byte
                        ack_q <= 1'b1;
                        reg_ptr_q <= reg_ptr_q + 8'h01;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // R11 data byte lands on the falling scl edge after its last bit
    wire write_strobe = bus_allowed & scl_fall & ~ack_q & ~tx_q & (bit_cnt_q == 4'h8) &
        (state_q == ST_DATA);
    reg [7:0] output1_control_d;
    reg [7:0] output2_control_d;

    // R1 per-output decode
    always @* begin
        output1_control_d = output1_control_q;
        output2_control_d = output2_control_q;
        if (write_strobe) begin
            // R10 reserved bits masked
            if (reg_ptr_q == `DBCSR_OUT1_CTRL_OFS)
                output1_control_d = shift_q & `DBCSR_CTRL_WMASK;
            else if (reg_ptr_q == `DBCSR_OUT2_CTRL_OFS)
                output2_control_d = shift_q & `DBCSR_CTRL_WMASK;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            output1_control_q <= `DBCSR_CTRL_RST;
            output2_control_q <= `DBCSR_CTRL_RST;
        end else begin
            output1_control_q <= output1_control_d;
            output2_control_q <= output2_control_d;
        end
    end

    reg [7:0] output1_ramp_cycles_d;
    reg [7:0] output2_ramp_cycles_d;
    reg output1_fixed_freq_d;
    reg output2_fixed_freq_d;
    reg output1_off_d;
    reg output2_off_d;

    always @* begin
        // R2 R3 ramp decode
        output1_ramp_cycles_d = ramp_cycles(
            output1_control_q[`DBCSR_SLEW_MSB:`DBCSR_SLEW_LSB]);
        output2_ramp_cycles_d = ramp_cycles(
            output2_control_q[`DBCSR_SLEW_MSB:`DBCSR_SLEW_LSB]);
        // R4 mode select
        output1_fixed_freq_d = fixed_freq(
            output1_control_q[`DBCSR_MODE_MSB:`DBCSR_MODE_LSB], pulse_skip_pin_i);
        output2_fixed_freq_d = fixed_freq(
            output2_control_q[`DBCSR_MODE_MSB:`DBCSR_MODE_LSB], pulse_skip_pin_i);
        // R5 output gate
        output1_off_d = output1_control_q[`DBCSR_OFF_BIT];
        output2_off_d = output2_control_q[`DBCSR_OFF_BIT];
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            output1_ramp_cycles_o <= 8'h01;
            output2_ramp_cycles_o <= 8'h01;
            output1_fixed_freq_o <= 1'b1;
            output2_fixed_freq_o <= 1'b1;
            output1_off_o <= 1'b0;
            output2_off_o <= 1'b0;
        end else begin
            output1_ramp_cycles_o <= output1_ramp_cycles_d;
            output2_ramp_cycles_o <= output2_ramp_cycles_d;
            output1_fixed_freq_o <= output1_fixed_freq_d;
            output2_fixed_freq_o <= output2_fixed_freq_d;
            output1_off_o <= output1_off_d;
            output2_off_o <= output2_off_d;
        end
    end

endmodule // dbcsr_regs

// ---- inc/dbcsr_regs.vh ----
// register offsets, field positions and reset values of the command/status bank
`ifndef DBCSR_REGS_VH
`define DBCSR_REGS_VH
`define DBCSR_OUT1_CTRL_OFS 8'h02
`define DBCSR_OUT2_CTRL_OFS 8'h03
`define DBCSR_HEALTH_OFS 8'h04
`define DBCSR_CTRL_RST 8'h00
`define DBCSR_HEALTH_RST 8'h00
`define DBCSR_CTRL_WMASK 8'h77
`define DBCSR_SLEW_MSB 6
`define DBCSR_SLEW_LSB 4
`define DBCSR_MODE_MSB 2
`define DBCSR_MODE_LSB 1
`define DBCSR_OFF_BIT 0
`define DBCSR_HOT_BIT 2
`define DBCSR_PG2_BIT 1
`define DBCSR_PG1_BIT 0
`define DBCSR_MODE_PIN 2'h0
`define DBCSR_MODE_FIXED 2'h1
`define DBCSR_MODE_AUTO 2'h2
`define DBCSR_SLAVE_ADDR 7'h60
`endif

// ---- tb/dbcsr_host.sv ----
// i2c host master model, sda open drain with pull-up in the bench, scl driven directly
`timescale 1ns/1ps
`include "dbcsr_regs.vh"
module dbcsr_host (
    input wire clk_i,
    input wire sda_i,
    output reg scl_o,
    output reg sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task ph;
        repeat (5) @(negedge clk_i);
    endtask
    task st;
        sda_o = 1'b1; ph; scl_o = 1'b1; ph; sda_o = 1'b0; ph; scl_o = 1'b0; ph;
    endtask
    task sp;
        sda_o = 1'b0; ph; scl_o = 1'b1; ph; sda_o = 1'b1; ph;
    endtask
    // one byte out msb first, ninth bit m driven by host, ack seen when sda low
    task xb(input [7:0] d, input m, output [7:0] r, output ack);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            sda_o = d[i]; ph; scl_o = 1'b1; ph; r[i] = sda_i; scl_o = 1'b0;
        end
        sda_o = m; ph; scl_o = 1'b1; ph; ack = !sda_i; scl_o = 1'b0; ph;
    endtask
    task wr(input [6:0] a, input [7:0] ofs, input [7:0] d, output ok);
        reg [7:0] r;
        reg k1, k2, k3;
        st; xb({a, 1'b0}, 1'b1, r, k1); xb(ofs, 1'b1, r, k2); xb(d, 1'b1, r, k3); sp;
        ok = k1 & k2 & k3;
    endtask
    task rd(input [7:0] ofs, output [7:0] d);
        reg [7:0] r;
        reg k;
        st; xb({`DBCSR_SLAVE_ADDR, 1'b0}, 1'b1, r, k); xb(ofs, 1'b1, r, k);
        st; xb({`DBCSR_SLAVE_ADDR, 1'b1}, 1'b1, r, k); xb(8'hff, 1'b1, d, k); sp;
    endtask
endmodule // dbcsr_host

// ---- tb/dbcsr_props.sv ----
// port checker for the command/status bank
`timescale 1ns/1ps
module dbcsr_props (
    input wire clk_i,
    input wire reset_i,
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire output1_hw_enable_pin_i,
    input wire output2_hw_enable_pin_i,
    input wire [7:0] output1_ramp_cycles_o,
    input wire [7:0] output2_ramp_cycles_o,
    input wire output1_off_o,
    input wire output2_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence idle_s;
        (!output1_hw_enable_pin_i && !output2_hw_enable_pin_i) [*3];
    endsequence
    a_reset_values: assert property (disable iff (1'b0) reset_i |=>
        output1_ramp_cycles_o == 8'h01 && output2_ramp_cycles_o == 8'h01 &&
        !output1_off_o && !output2_off_o) else $error("outputs not at reset values");
    a_ramp1_power: assert property ($onehot(output1_ramp_cycles_o))
        else $error("ramp one not a power of two");
    a_ramp2_power: assert property ($onehot(output2_ramp_cycles_o))
        else $error("ramp two not a power of two");
    a_sda_pull_only: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_idle_holds: assert property (idle_s |-> $stable(output1_off_o) &&
        $stable(output2_off_o) && $stable(output1_ramp_cycles_o) &&
        $stable(output2_ramp_cycles_o)) else $error("update while hardware off");
    a_idle_no_ack: assert property (idle_s |-> sda_oe_n_o)
        else $error("sda pulled while hardware off");
    a_sda_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
        else $error("sda moved while scl high");
    a_one_output: assert property (!(($changed(output1_off_o) ||
        $changed(output1_ramp_cycles_o)) && ($changed(output2_off_o) ||
        $changed(output2_ramp_cycles_o)))) else $error("both outputs changed at once");
endmodule // dbcsr_props
bind dbcsr_regs dbcsr_props u_props (.clk_i, .reset_i, .scl_i, .sda_o, .sda_oe_n_o,
    .output1_hw_enable_pin_i, .output2_hw_enable_pin_i, .output1_ramp_cycles_o,
    .output2_ramp_cycles_o, .output1_off_o, .output2_off_o);

// ---- tb/tb.sv ----
// self-checking bench of the command/status bank
`timescale 1ns/1ps
`include "dbcsr_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb;
    reg clk_i = 0, reset_i = 1, en1 = 1, en2 = 1, hot = 0, pg1 = 0, pg2 = 0, skip = 0;
    wire scl, hsda, sda_o, sda_oe_n, ff1, ff2, off1, off2;
    wire [7:0] ramp1, ramp2;
    wire sda = hsda & (sda_oe_n | sda_o);
    integer bad_count = 0, n_tests = 0;
    reg ok;
    reg [7:0] r;
    reg [3:0] i, m;
    dbcsr_host host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
    dbcsr_regs dut (.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .output1_hw_enable_pin_i(en1),
        .output2_hw_enable_pin_i(en2), .thermal_warning_i(hot),
        .output1_in_regulation_i(pg1), .output2_in_regulation_i(pg2),
        .pulse_skip_pin_i(skip), .output1_ramp_cycles_o(ramp1),
        .output2_ramp_cycles_o(ramp2), .output1_fixed_freq_o(ff1),
        .output2_fixed_freq_o(ff2), .output1_off_o(off1), .output2_off_o(off2));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task end_sim;
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task t_reset;
        host.rd(`DBCSR_OUT1_CTRL_OFS, r); `CHK(r, `DBCSR_CTRL_RST)
        host.rd(`DBCSR_OUT2_CTRL_OFS, r); `CHK(r, `DBCSR_CTRL_RST)
        host.rd(`DBCSR_HEALTH_OFS, r); `CHK(r, `DBCSR_HEALTH_RST)
        `CHK({ramp1, ramp2, off1, off2, ff1, ff2}, 20'h01013)
    endtask
    task t_ramp;
        for (i = 0; i < 8; i = i + 1) begin
            host.wr(`DBCSR_SLAVE_ADDR, 8'h02, {1'b0, i[2:0], 4'h0}, ok); `CHK(ok, 1'b1)
            `CHK(ramp1, 8'h01 << i)
            `CHK(ramp2, 8'h01)
        end
        host.wr(`DBCSR_SLAVE_ADDR, 8'h03, 8'hff, ok);
        host.rd(8'h03, r); `CHK(r, `DBCSR_CTRL_WMASK)
        `CHK({ramp2, off2, off1}, 10'h202)
        host.wr(`DBCSR_SLAVE_ADDR, 8'h03, 8'h00, ok); `CHK(off2, 1'b0)
    endtask
    task t_mode;
        for (m = 0; m < 8; m = m + 1) begin
            skip = m[0];
            host.wr(`DBCSR_SLAVE_ADDR, 8'h02, {5'h0, m[2:1], 1'b0}, ok);
            `CHK(ff1, m[2:1] == 2'h1 || m[2:1] == 2'h3 || m == 4'h0)
            host.wr(`DBCSR_SLAVE_ADDR, 8'h03, {5'h0, m[2:1], 1'b0}, ok);
            `CHK(ff2, m[2:1] == 2'h1 || m[2:1] == 2'h3 || m == 4'h0)
        end
    endtask
    task t_status;
        for (i = 0; i < 8; i = i + 1) begin
            {hot, pg2, pg1} = i[2:0];
            host.wr(`DBCSR_SLAVE_ADDR, `DBCSR_HEALTH_OFS, 8'hff, ok);
            host.rd(`DBCSR_HEALTH_OFS, r); `CHK(r, {5'h0, i[2:0]})
        end
    endtask
    task t_hw;
        en1 = 0; en2 = 0;
        host.wr(`DBCSR_SLAVE_ADDR, 8'h02, 8'h01, ok); `CHK({ok, off1}, 2'h0)
        en2 = 1;
        host.wr(`DBCSR_SLAVE_ADDR, 8'h02, 8'h01, ok); `CHK({ok, off1}, 2'h3)
        host.wr(`DBCSR_SLAVE_ADDR ^ 7'h01, 8'h02, 8'h00, ok); `CHK({ok, off1}, 2'h1)
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (20) @(negedge clk_i);
        reset_i = 0;
        repeat (3) @(negedge clk_i);
        t_reset; t_ramp; t_mode; t_status; t_hw;
        end_sim;
    end
endmodule // tb
